// file: pkg/fsrl_pkg.sv
// Constants, opcodes and carrier types of the flash status register logic.
// Assumes one core clock at CORE_MHZ and a mode 0 serial link.
package fsrl_pkg;

   // Instruction opcodes.
   localparam logic [7:0] OPC_STAT_WR   = 8'h01;
   localparam logic [7:0] OPC_PROG      = 8'h02;
   localparam logic [7:0] OPC_LATCH_CLR = 8'h04;
   localparam logic [7:0] OPC_STAT_RD   = 8'h05;
   localparam logic [7:0] OPC_LATCH_SET = 8'h06;
   localparam logic [7:0] OPC_SECT      = 8'h20;
   localparam logic [7:0] OPC_SECT_ALT  = 8'hD7;
   localparam logic [7:0] OPC_ERASE32   = 8'h52;
   localparam logic [7:0] OPC_ERASE64   = 8'hD8;
   localparam logic [7:0] OPC_CHIP      = 8'hC7;
   localparam logic [7:0] OPC_CHIP_ALT  = 8'h60;
   localparam logic [7:0] OPC_SUSPEND   = 8'h75;
   localparam logic [7:0] OPC_RESUME    = 8'h7A;
   localparam logic [7:0] OPC_RESET     = 8'h99;
   localparam logic [7:0] OPC_VOL_WR    = 8'hC0;

   // Frame byte counts, the opcode included.
   localparam logic [2:0] NB_DATA1 = 3'h2;
   localparam logic [2:0] NB_ADDR  = 3'h4;
   localparam logic [2:0] NB_PROG  = 3'h5;
   localparam logic [2:0] NB_MAX   = 3'h5;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // Address map: 4 Kbyte sectors, 32 and 64 Kbyte blocks.
   localparam int ADDR_W   = 24;
   localparam int SECT_LSB = 12;
   localparam int B32_LSB  = 15;
   localparam int B64_LSB  = 16;

   // Internal operation times in microseconds.
   localparam int CORE_MHZ  = 20;
   localparam int T_PROG_US = 1000;
   localparam int T_SECT_US = 50000;
   localparam int T_B32_US  = 150000;
   localparam int T_B64_US  = 200000;
   localparam int T_CHIP_US = 1000000;
   localparam int T_STWR_US = 2000;
   localparam int CNT_W     = 26;

   typedef struct packed {
      logic       status_write_disable;
      logic       quad_enable;
      logic [3:0] protect;
      logic       write_enable_latch;
      logic       busy_flag;
   } fsrl_stat_s;

   localparam logic [7:0] STAT_RST = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE, OP_PROG, OP_SECT, OP_B32, OP_B64, OP_CHIP, OP_STWR
   } fsrl_op_e;

   typedef struct packed {
      fsrl_op_e    kind;
      logic [11:0] sector;
      logic [8:0]  blk32;
      logic [7:0]  blk64;
   } fsrl_op_s;

   // One captured frame, handed from the link to the core.
   typedef struct packed {
      logic        fid;
      logic [7:0]  opc;
      logic [2:0]  nb;
      logic [2:0]  bitn;
      logic [31:0] cap;
   } fsrl_cmd_s;

endpackage

// file: core/fsrl_core.sv
// Status register, write-enable latch and busy sequencing of a serial
// flash, with the serial link front end on its own clock.
// Assumes a mode 0 host on SCK and CE_N, and WP_N from a pin.
//
// Operation
// - Array is uniform 4 KB sectors; 32 KB and 64 KB blocks group them.
// - Reading past the register end repeats the same value until deselect.
// - Status byte: busy, latch, four protect bits, quad enable, disable.
// - Protect bits, quad enable and disable bit start at zero.
// - Busy reads one during an internal cycle, zero when ready.
// - Busy is read-only and covers every program, erase, status write.
// - While busy, all but status read, reset and (outside a status write) suspend are ignored.
// - Suspend is still taken during a running program or erase.
// - Busy clears when the operation ends, then commands are taken.
// - Bit 1 shows the write-enable latch, zero by default.
// - Only enable, disable and reset commands and completion alter the latch; status write data not.
// - With the latch clear, program, erase and status write are refused.
// - The enable command sets the latch.
// - The latch clears at end of any write and on disable command.
// - Volatile register writes need no latch.
// - Bits 2 to 5 are protection controls, one means protected.
// - Protect, quad and disable bits change only by status write.
// - Bit 6 one enables the quad data function.
// - Bit 7 is the status write-disable control.
// - Disable set with write-protect low makes status write ignored.
// - Status read returns the whole status register.
`timescale 1ns/1ns
module fsrl_core
   import fsrl_pkg::*;
#(
   parameter logic [CNT_W-1:0] PROG_CYC = CNT_W'(T_PROG_US * CORE_MHZ),
   parameter logic [CNT_W-1:0] SECT_CYC = CNT_W'(T_SECT_US * CORE_MHZ),
   parameter logic [CNT_W-1:0] B32_CYC  = CNT_W'(T_B32_US * CORE_MHZ),
   parameter logic [CNT_W-1:0] B64_CYC  = CNT_W'(T_B64_US * CORE_MHZ),
   parameter logic [CNT_W-1:0] CHIP_CYC = CNT_W'(T_CHIP_US * CORE_MHZ),
   parameter logic [CNT_W-1:0] STWR_CYC = CNT_W'(T_STWR_US * CORE_MHZ)
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST,
   input  wire logic       SCK,
   input  wire logic       CE_N,
   input  wire logic       SI,
   input  wire logic       WP_N,
   output logic            SO_O,
   output logic            SO_OE,
   output logic [7:0]      STATUS,
   output logic            QUAD_EN,
   output logic [3:0]      PROTECT,
   output logic            OP_REQ,
   output fsrl_op_s        OP,
   output logic            OP_DONE,
   output logic            VOL_WR,
   output logic [7:0]      VOL_DATA
);

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSP} fsrl_st_e;

   // Link side, clocked by SCK.
   logic        first_r;
   logic        fid_r;
   logic [2:0]  bit_r;
   logic [2:0]  nb_r;
   logic [6:0]  sh_r;
   logic [7:0]  opc_r;
   logic [31:0] cap_r;
   logic        so_r;
   logic        so_en_r;
   logic        lrst;
   logic [2:0]  bit_eff;
   logic [2:0]  nb_eff;
   logic [7:0]  byte_in;

   // Core side.
   logic           ce_s1_r, ce_s2_r, ce_prev_r;
   logic           wp_s1_r, wp_s2_r;
   logic           fid_seen_r;
   fsrl_st_e       st_r;
   fsrl_op_e       kind_r;
   logic [CNT_W-1:0] cnt_r;
   logic           wel_r;
   logic [5:0]     nv_r;
   logic [5:0]     nv_pend_r;
   logic [7:0]     hold_r;
   fsrl_cmd_s      cmd;
   fsrl_stat_s     stat;
   logic           take;
   logic           busy;
   logic           wr_ok;
   logic           done;
   fsrl_op_e       start_kind;

   // Index of the sector and blocks holding a byte address.
   function automatic fsrl_op_s make_op(fsrl_op_e k,
                                        logic [ADDR_W-1:0] a);
      fsrl_op_s o;
      o.kind   = k;
      o.sector = a[ADDR_W-1:SECT_LSB];
      o.blk32  = a[ADDR_W-1:B32_LSB];
      o.blk64  = a[ADDR_W-1:B64_LSB];
      return o;
   endfunction

   function automatic logic [CNT_W-1:0] op_cycles(fsrl_op_e k);
      case (k)
         OP_PROG: op_cycles = PROG_CYC;
         OP_SECT: op_cycles = SECT_CYC;
         OP_B32:  op_cycles = B32_CYC;
         OP_B64:  op_cycles = B64_CYC;
         OP_CHIP: op_cycles = CHIP_CYC;
         default: op_cycles = STWR_CYC;
      endcase
   endfunction

   // Deselect clears the frame marker and the output drive; captured bytes stay for the
   // core to read once CE_N is high and SCK has stopped.
   assign lrst    = RST | CE_N;
   assign bit_eff = first_r ? 3'h0 : bit_r;
   assign nb_eff  = first_r ? 3'h0 : nb_r;
   assign byte_in = {sh_r, SI};

   always_ff @(posedge SCK or posedge lrst) begin
      if (lrst) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   always_ff @(posedge SCK or posedge RST) begin
      if (RST) begin
         fid_r <= 1'b0;
         bit_r <= 3'h0;
         nb_r  <= 3'h0;
         sh_r  <= 7'h00;
         opc_r <= 8'h00;
         cap_r <= 32'h0000_0000;
      end else begin
         if (first_r) begin
            fid_r <= ~fid_r;
         end
         bit_r <= bit_eff + 3'h1;
         sh_r  <= byte_in[6:0];
         nb_r  <= nb_eff;
         if (bit_eff == BIT_LAST) begin
            if (nb_eff == 3'h0) begin
               opc_r <= byte_in;
            end else if (nb_eff < NB_MAX) begin
               cap_r[(3'h4 - nb_eff) * 8 +: 8] <= byte_in;
            end
            if (nb_eff < NB_MAX) begin
               nb_r <= nb_eff + 3'h1;
            end
         end
      end
   end

   // The snapshot is frozen for the whole frame, so repeated bytes are
   // identical even if the core state moves on.
   always_ff @(negedge SCK or posedge lrst) begin
      if (lrst) begin
         so_r    <= 1'b0;
         so_en_r <= 1'b0;
      end else begin
         so_en_r <= (nb_r != 3'h0) && (opc_r == OPC_STAT_RD);
         so_r    <= hold_r[BIT_LAST - bit_r];
      end
   end

   assign SO_O  = so_r;
   assign SO_OE = so_en_r;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ce_s1_r   <= 1'b1;
         ce_s2_r   <= 1'b1;
         ce_prev_r <= 1'b1;
         wp_s1_r   <= 1'b1;
         wp_s2_r   <= 1'b1;
      end else begin
         ce_s1_r   <= CE_N;
         ce_s2_r   <= ce_s1_r;
         ce_prev_r <= ce_s2_r;
         wp_s1_r   <= WP_N;
         wp_s2_r   <= wp_s1_r;
      end
   end

   // A frame is taken once per deselect, and only if it moved SCK.
   assign cmd  = '{fid: fid_r, opc: opc_r, nb: nb_r, bitn: bit_r,
                   cap: cap_r};
   assign take = ce_s2_r && !ce_prev_r && (cmd.fid != fid_seen_r)
                 && (cmd.bitn == 3'h0) && (cmd.nb != 3'h0);

   assign busy  = (st_r == ST_RUN);
   assign wr_ok = (st_r == ST_IDLE) && wel_r;
   assign done  = busy && (cnt_r == '0);

   always_comb begin
      start_kind = OP_NONE;
      if (take && wr_ok) begin
         case (cmd.opc)
            OPC_STAT_WR: begin
               if (cmd.nb >= NB_DATA1
                   && !(nv_r[5] && !wp_s2_r)) begin
                  start_kind = OP_STWR;
               end
            end
            OPC_PROG: begin
               if (cmd.nb >= NB_PROG) begin
                  start_kind = OP_PROG;
               end
            end
            OPC_SECT, OPC_SECT_ALT: begin
               if (cmd.nb >= NB_ADDR) begin
                  start_kind = OP_SECT;
               end
            end
            OPC_ERASE32: begin
               if (cmd.nb >= NB_ADDR) begin
                  start_kind = OP_B32;
               end
            end
            OPC_ERASE64: begin
               if (cmd.nb >= NB_ADDR) begin
                  start_kind = OP_B64;
               end
            end
            OPC_CHIP, OPC_CHIP_ALT: begin
               if (nv_r[3:0] == 4'h0) begin
                  start_kind = OP_CHIP;
               end
            end
            default: start_kind = OP_NONE;
         endcase
      end
   end

   // Sequencer of internal operations and of suspend.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         st_r       <= ST_IDLE;
         kind_r     <= OP_NONE;
         cnt_r      <= '0;
         fid_seen_r <= 1'b0;
      end else begin
         if (ce_s2_r && !ce_prev_r) begin
            fid_seen_r <= cmd.fid;
         end
         case (st_r)
            ST_IDLE: begin
               if (start_kind != OP_NONE) begin
                  st_r   <= ST_RUN;
                  kind_r <= start_kind;
                  cnt_r  <= op_cycles(start_kind) - 1'b1;
               end
            end
            ST_RUN: begin
               if (take && cmd.opc == OPC_RESET) begin
                  st_r <= ST_IDLE;
               end else if (take && cmd.opc == OPC_SUSPEND
                            && kind_r != OP_STWR) begin
                  st_r <= ST_SUSP;
               end else if (done) begin
                  st_r <= ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 1'b1;
               end
            end
            ST_SUSP: begin
               if (take && cmd.opc == OPC_RESET) begin
                  st_r <= ST_IDLE;
               end else if (take && cmd.opc == OPC_RESUME) begin
                  st_r <= ST_RUN;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // A set in the cycle of an automatic clear is ignored, since set needs not busy.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         wel_r <= 1'b0;
      end else if (take && !busy && cmd.opc == OPC_LATCH_SET) begin
         wel_r <= 1'b1;
      end else if (take && cmd.opc == OPC_RESET) begin
         wel_r <= 1'b0;
      end else if (take && !busy && cmd.opc == OPC_LATCH_CLR) begin
         wel_r <= 1'b0;
      end else if (done) begin
         wel_r <= 1'b0;
      end
   end

   // Non-volatile bits commit only when a status write completes.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         nv_r      <= STAT_RST[7:2];
         nv_pend_r <= STAT_RST[7:2];
      end else begin
         if (start_kind == OP_STWR) begin
            nv_pend_r <= cmd.cap[31:26];
         end
         if (done && kind_r == OP_STWR) begin
            nv_r <= nv_pend_r;
         end
      end
   end

   assign stat = '{status_write_disable: nv_r[5],
                   quad_enable:          nv_r[4],
                   protect:              nv_r[3:0],
                   write_enable_latch:   wel_r,
                   busy_flag:            busy};

   // Status outputs and pulses refreshed every cycle, OP and VOL_DATA on start or write; the frame snapshot only while deselected.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         hold_r   <= STAT_RST;
         STATUS   <= STAT_RST;
         QUAD_EN  <= 1'b0;
         PROTECT  <= 4'h0;
         OP_REQ   <= 1'b0;
         OP       <= '0;
         OP_DONE  <= 1'b0;
         VOL_WR   <= 1'b0;
         VOL_DATA <= 8'h00;
      end else begin
         if (ce_s2_r) begin
            hold_r <= stat;
         end
         STATUS  <= stat;
         QUAD_EN <= stat.quad_enable;
         PROTECT <= stat.protect;
         OP_REQ  <= (start_kind != OP_NONE);
         if (start_kind != OP_NONE) begin
            OP <= make_op(start_kind, cmd.cap[31:8]);
         end
         OP_DONE <= done;
         VOL_WR  <= take && !busy && cmd.opc == OPC_VOL_WR
                    && cmd.nb >= NB_DATA1;
         if (take && !busy && cmd.opc == OPC_VOL_WR) begin
            VOL_DATA <= cmd.cap[31:24];
         end
      end
   end

endmodule

// file: sim/fsrl_core_monitor.sv
// Port checks for the flash status register logic, core clock domain.
// Assumes the bind below attaches it to every instance of the core.
`timescale 1ns/1ns
module fsrl_core_monitor (
   input wire logic       CORE_CLK,
   input wire logic       RST,
   input wire logic       CE_N,
   input wire logic       SO_OE,
   input wire logic [7:0] STATUS,
   input wire logic       QUAD_EN,
   input wire logic [3:0] PROTECT,
   input wire logic       OP_REQ,
   input wire logic       OP_DONE
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_quad_mirror: assert property (QUAD_EN == STATUS[6])
      else $error("quad enable differs from status bit 6");
   a_prot_mirror: assert property (PROTECT == STATUS[5:2])
      else $error("protect output differs from status bits");
   a_req_busy: assert property (OP_REQ |=> STATUS[0])
      else $error("operation started without busy");
   a_busy_hold: assert property (OP_REQ |=> STATUS[0] [*8])
      else $error("busy dropped right after start");
   a_done_clear: assert property (
      OP_DONE |-> ##[0:1] (STATUS[1:0] == 2'b00))
      else $error("busy or latch left set after completion");
   a_done_busy: assert property (OP_DONE |-> $past(STATUS[0]))
      else $error("completion while not busy");
   a_req_latch: assert property (OP_REQ |-> $past(STATUS[1]))
      else $error("operation started with latch clear");
   a_nv_write: assert property (
      $changed(STATUS[7:2]) |-> (OP_DONE || $past(OP_DONE)))
      else $error("protected bits changed outside completion");
   a_so_release: assert property (CE_N |-> !SO_OE)
      else $error("output driven while deselected");
   c_start: cover property (OP_REQ);
   c_done: cover property (OP_DONE);
   c_read: cover property ($fell(SO_OE));
endmodule

bind fsrl_core fsrl_core_monitor i_mon (.CORE_CLK(CORE_CLK), .RST(RST),
   .CE_N(CE_N), .SO_OE(SO_OE), .STATUS(STATUS), .QUAD_EN(QUAD_EN),
   .PROTECT(PROTECT), .OP_REQ(OP_REQ), .OP_DONE(OP_DONE));

// file: sim/fsrl_host.sv
// Serial host model: mode 0, 125 ns clock that runs only inside frames.
// Assumes callers leave it idle between frames.
`timescale 1ns/1ns
module fsrl_host (
   output logic      SCK,
   output logic      CE_N,
   output logic      SI,
   input  wire logic SO_O,
   input  wire logic SO_OE
);
   initial begin
      SCK = 1'b0;
      CE_N = 1'b1;
      SI = 1'b0;
   end
   // Sends n bytes from the top of tx and returns the last 16 bits read.
   task automatic frame(input logic [39:0] tx, input int n,
                        output logic [15:0] rx);
      rx = 16'h0000;
      #7 CE_N = 1'b0;
      for (int i = 0; i < n * 8; i++) begin
         #31 SI = tx[39-i];
         #31 SCK = 1'b1;
         rx = {rx[14:0], (SO_OE === 1'b1) ? SO_O : 1'bx};
         #63 SCK = 1'b0;
      end
      #62 CE_N = 1'b1;
      SI = ~SI;
      #400;
   endtask
endmodule

// file: sim/fsrl_core_tb.sv
// Self-checking bench for the flash status register logic.
// Assumes the host model and the bound port monitor.
`timescale 1ns/1ns
module fsrl_core_tb;
   import fsrl_pkg::*;
   logic        CORE_CLK, RST, WP_N, SCK, CE_N, SI, SO_O, SO_OE;
   logic        QUAD_EN, OP_REQ, OP_DONE, VOL_WR;
   logic [7:0]  STATUS, VOL_DATA;
   logic [3:0]  PROTECT;
   fsrl_op_s    OP;
   logic [15:0] rx;
   int          bad_count = 0;
   int          tests_run = 0;
   int          vol_n = 0;
   logic [7:0]  opl[7] = '{OPC_CHIP, OPC_CHIP_ALT, OPC_PROG, OPC_ERASE32,
                           OPC_ERASE64, OPC_SECT_ALT, OPC_SECT};
   fsrl_op_e    kd[7] = '{OP_CHIP, OP_CHIP, OP_PROG, OP_B32, OP_B64,
                          OP_SECT, OP_SECT};

   // Volatile write pulses are counted away from the edge that makes them.
   always @(negedge CORE_CLK) begin
      if (VOL_WR === 1'b1) begin
         vol_n++;
      end
   end

   // Program keeps its full default time; the other operations are cut short.
   fsrl_core #(.SECT_CYC(26'h12C), .B32_CYC(26'h12C), .B64_CYC(26'h12C),
      .CHIP_CYC(26'h12C), .STWR_CYC(26'h12C))
   i_fsrl_core (.CORE_CLK(CORE_CLK), .RST(RST), .SCK(SCK), .CE_N(CE_N),
      .SI(SI), .WP_N(WP_N), .SO_O(SO_O), .SO_OE(SO_OE), .STATUS(STATUS),
      .QUAD_EN(QUAD_EN), .PROTECT(PROTECT), .OP_REQ(OP_REQ), .OP(OP),
      .OP_DONE(OP_DONE), .VOL_WR(VOL_WR), .VOL_DATA(VOL_DATA));
   fsrl_host i_fsrl_host (.SCK(SCK), .CE_N(CE_N), .SI(SI), .SO_O(SO_O),
      .SO_OE(SO_OE));

   initial begin
      CORE_CLK = 1'b0;
      forever #25 CORE_CLK = ~CORE_CLK;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("comparisons=%0d mismatches=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmd(input logic [39:0] tx, input int n);
      i_fsrl_host.frame(tx, n, rx);
   endtask

   // Waits for the completion pulse, then lets the status settle.
   task automatic wait_done;
      int k;
      k = 0;
      do begin
         @(posedge CORE_CLK);
         #1;
         k++;
      end while (OP_DONE !== 1'b1 && k < 25000);
      chk(k < 25000, 32'h1);
      #400;
   endtask

   initial begin
      #2000000;
      bad_count++;
      finish_test;
   end

   initial begin
      RST = 1'b1;
      WP_N = 1'b1;
      repeat (20) @(posedge CORE_CLK);
      RST <= 1'b0;
      #400;
      chk(STATUS, STAT_RST);
      chk({QUAD_EN, PROTECT}, 5'h00);
      cmd({OPC_STAT_RD, 32'h0}, 3);
      chk(rx, 16'h0000);
      cmd({OPC_LATCH_SET, 32'h0}, 1);
      chk(STATUS, 8'h02);
      cmd({OPC_STAT_RD, 32'h0}, 3);
      chk(rx, 16'h0202);
      cmd({OPC_LATCH_CLR, 32'h0}, 1);
      chk(STATUS, 8'h00);
      cmd({OPC_SECT, 24'h123456, 8'h00}, 4);
      chk(STATUS, 8'h00);
      cmd({OPC_VOL_WR, 8'h5A, 24'h0}, 2);
      chk(VOL_DATA, 8'h5A);
      chk(vol_n, 1);
      for (int i = 0; i < 7; i++) begin
         cmd({OPC_LATCH_SET, 32'h0}, 1);
         cmd({opl[i], 24'h123456, 8'hA5}, 5);
         chk(OP.kind, kd[i]);
         cmd({OPC_LATCH_CLR, 32'h0}, 1);
         cmd({OPC_VOL_WR, 8'h00, 24'h0}, 2);
         cmd({OPC_STAT_RD, 32'h0}, 3);
         chk(rx, 16'h0303);
         wait_done;
         chk(STATUS, 8'h00);
      end
      chk(vol_n, 1);
      chk(VOL_DATA, 8'h5A);
      chk({OP.sector, OP.blk32, OP.blk64}, {12'h123, 9'h024, 8'h12});
      cmd({OPC_LATCH_SET, 32'h0}, 1);
      cmd({OPC_STAT_WR, 8'hC4, 24'h0}, 2);
      chk(STATUS, 8'h03);
      wait_done;
      chk(STATUS, 8'hC4);
      chk({QUAD_EN, PROTECT}, 5'h11);
      @(posedge CORE_CLK) WP_N <= 1'b0;
      cmd({OPC_LATCH_SET, 32'h0}, 1);
      cmd({OPC_STAT_WR, 8'h00, 24'h0}, 2);
      chk(STATUS, 8'hC6);
      @(posedge CORE_CLK) WP_N <= 1'b1;
      cmd({OPC_STAT_WR, 8'h00, 24'h0}, 2);
      chk(STATUS, 8'hC7);
      wait_done;
      chk(STATUS, 8'h00);
      cmd({OPC_LATCH_SET, 32'h0}, 1);
      cmd({OPC_PROG, 24'h001000, 8'h3C}, 5);
      cmd({OPC_SUSPEND, 32'h0}, 1);
      chk(STATUS, 8'h02);
      cmd({OPC_RESUME, 32'h0}, 1);
      chk(STATUS, 8'h03);
      cmd({OPC_RESET, 32'h0}, 1);
      chk(STATUS, 8'h00);
      finish_test;
   end
endmodule
